// File: dar_conv.sv
// conversion sequencer: start, hold, per-channel done, busy, results
`timescale 1ns/10ps
module dar_conv
#(
    parameter int CONV_CYC = dar_pkg::CONV_CH_CYC,
    parameter int ACQ_LEN = dar_pkg::ACQ_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start_n_s,
    input wire logic power_down_s,
    input wire logic low_power_s,
    input wire logic [dar_pkg::RES_W-1:0] code_a,
    input wire logic [dar_pkg::RES_W-1:0] code_b,
    output logic busy,
    output logic channel_done_n,
    output logic hold,
    output logic latch,
    output logic [dar_pkg::RES_W-1:0] result_a,
    output logic [dar_pkg::RES_W-1:0] result_b
);
    import dar_pkg::*;

    initial
    begin
        if (CONV_CYC < 4 || CONV_CYC > 65535 || ACQ_LEN < 1
            || ACQ_LEN > 65535)
            $error("dar_conv: cycle counts out of range");
    end

    dar_conv_e state_reg;
    logic [15:0] cnt_reg;
    logic start_prev_reg;
    logic conv_end;
    logic acq_end;
    logic go;

    assign conv_end = cnt_reg == 16'(CONV_CYC - 1);
    assign acq_end = cnt_reg == 16'(ACQ_LEN - 1);

    // falling start edge in idle, or start still low after acquisition
    // in low-power mode; power-down only refuses new starts
    assign go = !power_down_s
        && ((state_reg == CV_IDLE && start_prev_reg && !start_n_s)
        || (state_reg == CV_ACQ && acq_end && low_power_s
        && !start_n_s));

    // start edge detector
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            start_prev_reg <= 1'b1;
        else
            start_prev_reg <= start_n_s;
    end

    // sequence: channel a, channel b, acquisition; reset aborts it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= CV_IDLE;
            cnt_reg <= 16'h0000;
        end
        else if (go)
        begin
            state_reg <= CV_CH_A;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                CV_CH_A, CV_CH_B:
                begin
                    cnt_reg <= conv_end ? 16'h0000 : cnt_reg + 16'h0001;
                    if (conv_end)
                        state_reg <= state_reg == CV_CH_A ? CV_CH_B : CV_ACQ;
                end
                CV_ACQ:
                begin
                    cnt_reg <= acq_end ? 16'h0000 : cnt_reg + 16'h0001;
                    if (acq_end)
                        state_reg <= CV_IDLE;
                end
                default:
                    cnt_reg <= 16'h0000;
            endcase
        end
    end

    assign hold = state_reg == CV_CH_A || state_reg == CV_CH_B;

    // results, done pulse per channel and latch pulse after channel b
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            result_a <= 16'h0000;
            result_b <= 16'h0000;
            channel_done_n <= 1'b1;
            latch <= 1'b0;
        end
        else
        begin
            channel_done_n <= !(hold && conv_end);
            latch <= state_reg == CV_CH_B && conv_end;
            if (state_reg == CV_CH_A && conv_end)
                result_a <= code_a;
            if (state_reg == CV_CH_B && conv_end)
                result_b <= code_b;
        end
    end

    // busy drops at the edge where the shift register takes the results
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            busy <= 1'b0;
        else if (go)
            busy <= 1'b1;
        else if (latch)
            busy <= 1'b0;
    end

    a_busy_on_start: assert property (@(posedge ref_clk) disable iff (rst)
        go |=> busy [*4]) else $error("busy not held after start");
    a_done_at_latch: assert property (@(posedge ref_clk) disable iff (rst)
        latch |-> !channel_done_n && busy ##1 !busy)
        else $error("busy or done wrong at latch");
    a_pd_no_start: assert property (@(posedge ref_clk) disable iff (rst)
        (power_down_s && !busy && state_reg != CV_ACQ) |=> !busy)
        else $error("start taken in power-down");
    a_reset_abort: assert property (@(posedge ref_clk)
        rst |=> !busy && !hold && channel_done_n)
        else $error("reset did not abort");
endmodule

// File: dar_core.sv
// dual converter control and result readout, parallel and serial port
// How it works
// - serial clock pin is output on internal clock, input on external
// - parallel mode drives shared pins as result bus bits, e.g. bit 10
// - internal clock serial mode drives a frame marker during reads
// - marker not inverted: high during read, low pulse after channel one
// - marker inverted: low during read, high pulse after channel one
// - slave read unfinished at next conversion end: drop data, flag pulse
// - bits 12 to 15 driven only in parallel mode
// - busy high from start until results sit in the shift register
// - channel done goes low once per finished channel
// - output bus enabled only while chip select and read both low, except the error flag pin on external clock
// - external serial clock edges ignored while chip select is high
// - reset returns to idle and aborts a conversion
// - power-down lets a conversion finish, then refuses new starts
// - start falling edge holds the sample and begins a conversion
// - low-power mode starts again if start is low after acquisition
// - both results in a 32-bit register, msb first, order selectable
// - external clock: data updates on rising edge, falling if inverted
// - read mode high shifts previous data during conversion, else after
// - external clock: chain input reaches data out after 32 clocks
`timescale 1ns/10ps
module dar_core
#(
    parameter int CONV_CYC = dar_pkg::CONV_CH_CYC,
    parameter int ACQ_LEN = dar_pkg::ACQ_CYC,
    parameter int SCLK_HALF = dar_pkg::SCLK_HALF_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conversion_start_n,
    input wire logic power_down,
    input wire logic low_power_mode,
    input wire logic port_type_select,
    input wire logic clock_source_select,
    input wire logic serial_clock_invert,
    input wire logic frame_marker_invert,
    input wire logic read_mode_or_chain_in,
    input wire logic channel_order_select,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic sclk_in,
    input wire logic [dar_pkg::RES_W-1:0] code_a,
    input wire logic [dar_pkg::RES_W-1:0] code_b,
    output logic [dar_pkg::PIN_W-1:0] d_out,
    output logic [dar_pkg::PIN_W-1:0] d_oe,
    output logic busy,
    output logic channel_done_n,
    output logic hold
);
    import dar_pkg::*;

    initial
    begin
        if (SCLK_HALF < 1 || SCLK_HALF > 255)
            $error("dar_core: SCLK_HALF out of range");
    end

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic cs_n_s, rd_n_s, sclk_s, chain_s, serial_s, ext_s;
    logic inv_s, finv_s, ord_s;
    logic en;
    logic latch;
    logic [RES_W-1:0] result_a;
    logic [RES_W-1:0] result_b;
    dar_read_e rd_state_reg;
    logic [SR_W-1:0] sr_reg;
    logic [5:0] bit_cnt_reg;
    logic [7:0] div_reg;
    logic phase_reg;
    logic sclk_prev_reg;
    logic fresh_reg;
    logic rderr_reg;
    logic tick;
    logic m_shift;
    logic upd_slv;
    logic start_m;
    logic start_s;
    logic frame_act;
    logic [PIN_W-1:0] d_out_next;
    logic [PIN_W-1:0] d_oe_next;

    // every pin input passes two flops before any logic reads it
    assign raw = {channel_order_select, low_power_mode, frame_marker_invert,
        serial_clock_invert, clock_source_select, port_type_select,
        read_mode_or_chain_in, sclk_in, power_down, conversion_start_n,
        rd_n, cs_n};

    generate
        for (genvar i = 0; i < SYNC_W; i++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    s1_reg[i] <= SYNC_RST[i];
                    s2_reg[i] <= SYNC_RST[i];
                end
                else
                begin
                    s1_reg[i] <= raw[i];
                    s2_reg[i] <= s1_reg[i];
                end
            end
        end
    endgenerate

    assign cs_n_s = s2_reg[SI_CS];
    assign rd_n_s = s2_reg[SI_RD];
    assign sclk_s = s2_reg[SI_SCLK];
    assign chain_s = s2_reg[SI_CHAIN];
    assign serial_s = s2_reg[SI_PTS];
    assign ext_s = s2_reg[SI_CSS];
    assign inv_s = s2_reg[SI_INV];
    assign finv_s = s2_reg[SI_FINV];
    assign ord_s = s2_reg[SI_ORD];

    assign en = !cs_n_s && !rd_n_s;

    // conversion timing, hold, busy and per-channel done
    dar_conv #(
        .CONV_CYC(CONV_CYC),
        .ACQ_LEN(ACQ_LEN)
    ) u_conv (
        .ref_clk(ref_clk),
        .rst(rst),
        .start_n_s(s2_reg[SI_CNV]),
        .power_down_s(s2_reg[SI_PWR]),
        .low_power_s(s2_reg[SI_LP]),
        .code_a(code_a),
        .code_b(code_b),
        .busy(busy),
        .channel_done_n(channel_done_n),
        .hold(hold),
        .latch(latch),
        .result_a(result_a),
        .result_b(result_b)
    );

    // internal serial clock: half-period divider, update on phase 1 to 0
    assign tick = div_reg == 8'(SCLK_HALF - 1);
    assign m_shift = rd_state_reg == RS_MST && en && tick && phase_reg
        && bit_cnt_reg != 6'd31;

    // external clock edge, only while chip select is low
    assign upd_slv = !cs_n_s && (inv_s ? (sclk_prev_reg && !sclk_s)
        : (!sclk_prev_reg && sclk_s));

    // master read with read mode high may run during conversion
    assign start_m = serial_s && !ext_s && en && fresh_reg
        && (chain_s || !busy);
    assign start_s = serial_s && ext_s && en && fresh_reg;

    // edge detector of the external clock reads the second flop only
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sclk_prev_reg <= 1'b0;
        else
            sclk_prev_reg <= sclk_s;
    end

    // unread data marker; a new latch wins over the clear of a read start
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            fresh_reg <= 1'b0;
        else if (latch)
            fresh_reg <= 1'b1;
        else if (rd_state_reg == RS_IDLE && (start_m || start_s))
            fresh_reg <= 1'b0;
    end

    // readout sequence; new results abort any read in progress
    always_ff @(posedge ref_clk)
    begin
        if (rst || latch)
            rd_state_reg <= RS_IDLE;
        else
        begin
            case (rd_state_reg)
                RS_IDLE:
                begin
                    if (start_m)
                        rd_state_reg <= RS_MST;
                    else if (start_s)
                        rd_state_reg <= RS_SLV;
                end
                RS_MST:
                begin
                    if (!en || (tick && phase_reg && bit_cnt_reg == 6'd31))
                        rd_state_reg <= RS_IDLE;
                end
                RS_SLV:
                begin
                    if (!en)
                        rd_state_reg <= RS_IDLE;
                end
                default:
                    rd_state_reg <= RS_IDLE;
            endcase
        end
    end

    // bit counter, divider and internal clock phase
    always_ff @(posedge ref_clk)
    begin
        if (rst || latch || rd_state_reg == RS_IDLE)
        begin
            bit_cnt_reg <= 6'd0;
            div_reg <= 8'h00;
            phase_reg <= 1'b0;
        end
        else if (rd_state_reg == RS_MST)
        begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            if (tick)
                phase_reg <= !phase_reg;
            if (m_shift)
                bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
        else if (upd_slv && en && bit_cnt_reg != 6'd32)
            bit_cnt_reg <= bit_cnt_reg + 6'd1; // saturates, chain goes on
    end

    // 32-bit output register, msb first, channel order by select input
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sr_reg <= 32'h0000_0000;
        else if (latch)
            sr_reg <= ord_s ? {result_b, result_a}
                : {result_a, result_b};
        else if (m_shift)
            sr_reg <= {sr_reg[SR_W-2:0], 1'b0};
        else if (rd_state_reg == RS_SLV && en && upd_slv)
            sr_reg <= {sr_reg[SR_W-2:0], chain_s};
    end

    // slave read begun but short of 32 clocks when new results arrive
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rderr_reg <= 1'b0;
        else
            rderr_reg <= latch && rd_state_reg == RS_SLV
                && bit_cnt_reg < 6'd32;
    end

    // marker gap for one half clock once the first channel is out
    assign frame_act = rd_state_reg == RS_MST
        && !(bit_cnt_reg == 6'd16 && !phase_reg);

    // pin values and enables, registered on the next edge
    always_comb
    begin
        d_out_next = 16'h0000;
        d_oe_next = 16'h0000;
        if (!serial_s)
        begin
            d_out_next = ord_s ? result_b : result_a;
            d_oe_next = {PIN_W{en}};
        end
        else
        begin
            d_out_next[PIN_SDATA] = sr_reg[SR_W-1];
            d_out_next[PIN_SCLK] = phase_reg ^ inv_s;
            d_out_next[PIN_FRAME] = frame_act ^ finv_s;
            d_out_next[PIN_RDERR] = rderr_reg;
            d_oe_next[PIN_SDATA] = en;
            d_oe_next[PIN_SCLK] = en && !ext_s;
            d_oe_next[PIN_FRAME] = en && !ext_s;
            d_oe_next[PIN_RDERR] = ext_s;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            d_out <= 16'h0000;
            d_oe <= 16'h0000;
        end
        else
        begin
            d_out <= d_out_next;
            d_oe <= d_oe_next;
        end
    end

    a_upper_hiz: assert property (@(posedge ref_clk) disable iff (rst)
        serial_s |=> d_oe[PIN_W-1:PIN_UPPER] == 4'h0)
        else $error("upper bits driven in serial mode");
    a_bus_gated: assert property (@(posedge ref_clk) disable iff (rst)
        !en |=> d_oe[PIN_FRAME:0] == 11'h000)
        else $error("bus driven without select and read");
    a_rderr_cause: assert property (@(posedge ref_clk) disable iff (rst)
        (latch && rd_state_reg == RS_SLV && bit_cnt_reg < 6'd32
        && serial_s && ext_s) |=> ##1 d_out[PIN_RDERR])
        else $error("incomplete read not flagged");
    a_frame_start: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_state_reg == RS_MST && bit_cnt_reg == 6'd0 && serial_s)
        |=> d_out[PIN_FRAME] == !$past(finv_s))
        else $error("frame marker wrong at read start");
    a_gate_sclk: assert property (@(posedge ref_clk) disable iff (rst)
        (cs_n_s && !latch) |=> $stable(sr_reg))
        else $error("shift while chip select high");
endmodule

// File: dar_host.sv
// host model that reads the serial port as master sink or slave clock
`timescale 1ns/10ps
module dar_host
(
    input wire logic ref_clk,
    input wire logic sclk_idle,
    input wire logic [dar_pkg::PIN_W-1:0] d_out,
    input wire logic [dar_pkg::PIN_W-1:0] d_oe,
    output logic sclk_in
);
    import dar_pkg::*;
    logic act = 1'b0;
    logic sdo;

    // a released data pin has no pull, so show the opposite level
    assign sdo = d_oe[PIN_SDATA] ? d_out[PIN_SDATA] : !d_out[PIN_SDATA];

    // the link clock rests at its idle level outside frames
    assign sclk_in = sclk_idle ^ act;

    // take a bit each time the device clock leaves its idle level
    task automatic master_read(output logic [31:0] w, output logic ok);
        int n;
        int k;
        logic prev;
        begin
            w = '0;
            k = 0;
            prev = sclk_idle;
            for (n = 0; n < 600 && k < 32; n++)
            begin
                @(posedge ref_clk);
                if (prev === sclk_idle && d_out[PIN_SCLK] === ~sclk_idle)
                begin
                    w = {w[30:0], sdo};
                    k++;
                end
                prev = d_out[PIN_SCLK];
            end
            ok = (k == 32);
        end
    endtask

    // 64 ns periods; a bit is taken just before its update edge
    task automatic slave_read(input int nb, output logic [39:0] w);
        int i;
        begin
            w = '0;
            for (i = 0; i < nb; i++)
            begin
                @(posedge ref_clk);
                w = {w[38:0], sdo};
                act <= 1'b1;
                repeat (4) @(posedge ref_clk);
                act <= 1'b0;
                repeat (3) @(posedge ref_clk);
            end
        end
    endtask
endmodule

// File: dar_pkg.sv
// shared constants and types of the dual converter control and readout
package dar_pkg;

    // clock and timing figures
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_CH_NS = 800; // time to convert one channel
    localparam int ACQ_NS = 250; // least acquisition time after a cycle
    localparam int CONV_CH_CYC = (CONV_CH_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 2; // internal serial clock half period

    // data widths
    localparam int RES_W = 16;
    localparam int SR_W = 32;
    localparam int PIN_W = 16;

    // shared pin positions used in serial mode
    localparam int PIN_SDATA = 8;
    localparam int PIN_SCLK = 9;
    localparam int PIN_FRAME = 10;
    localparam int PIN_RDERR = 11;
    localparam int PIN_UPPER = 12;

    // positions in the input synchroniser vector
    localparam int SI_CS = 0;
    localparam int SI_RD = 1;
    localparam int SI_CNV = 2;
    localparam int SI_PWR = 3;
    localparam int SI_SCLK = 4;
    localparam int SI_CHAIN = 5;
    localparam int SI_PTS = 6;
    localparam int SI_CSS = 7;
    localparam int SI_INV = 8;
    localparam int SI_FINV = 9;
    localparam int SI_LP = 10;
    localparam int SI_ORD = 11;
    localparam int SYNC_W = 12;
    // strobes idle high, everything else low
    localparam logic [SYNC_W-1:0] SYNC_RST = 12'h007;

    // conversion sequencer states
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_CH_A = 2'b01,
        CV_CH_B = 2'b10,
        CV_ACQ = 2'b11
    } dar_conv_e;

    // readout states
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_MST = 2'b01,
        RS_SLV = 2'b10
    } dar_read_e;

endpackage

// File: test_dar_core.sv
// self-checking bench of the dual converter control and readout block
`timescale 1ns/10ps
module test_dar_core;
    import dar_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic conversion_start_n = 1'b1;
    logic power_down = 1'b0;
    logic low_power_mode = 1'b0;
    logic port_type_select = 1'b0;
    logic clock_source_select = 1'b0;
    logic serial_clock_invert = 1'b0;
    logic frame_marker_invert = 1'b0;
    logic read_mode_or_chain_in = 1'b0;
    logic channel_order_select = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic sclk_in;
    logic [RES_W-1:0] code_a = 16'h0000;
    logic [RES_W-1:0] code_b = 16'h0000;
    logic [PIN_W-1:0] d_out;
    logic [PIN_W-1:0] d_oe;
    logic busy;
    logic channel_done_n;
    logic hold;
    logic in_read = 1'b0;
    int done_cnt = 0;
    int rderr_cnt = 0;
    int gap_cnt = 0;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] exp_q[$];

    // 125 MHz reference clock
    always #4 ref_clk = ~ref_clk;

    dar_core dut (.ref_clk(ref_clk), .rst(rst),
        .conversion_start_n(conversion_start_n), .power_down(power_down),
        .low_power_mode(low_power_mode), .port_type_select(port_type_select),
        .clock_source_select(clock_source_select),
        .serial_clock_invert(serial_clock_invert),
        .frame_marker_invert(frame_marker_invert),
        .read_mode_or_chain_in(read_mode_or_chain_in),
        .channel_order_select(channel_order_select), .cs_n(cs_n),
        .rd_n(rd_n), .sclk_in(sclk_in), .code_a(code_a), .code_b(code_b),
        .d_out(d_out), .d_oe(d_oe), .busy(busy),
        .channel_done_n(channel_done_n), .hold(hold));

    dar_host host (.ref_clk(ref_clk), .sclk_idle(serial_clock_invert),
        .d_out(d_out), .d_oe(d_oe), .sclk_in(sclk_in));

    // event counters; done and flag pulses are one cycle wide, the gap counter counts cycles
    always @(posedge ref_clk)
    begin
        if (channel_done_n === 1'b0)
            done_cnt <= done_cnt + 1;
        if (d_oe[PIN_RDERR] === 1'b1 && d_out[PIN_RDERR] === 1'b1)
            rderr_cnt <= rderr_cnt + 1;
        if (in_read && d_out[PIN_FRAME] === frame_marker_invert)
            gap_cnt <= gap_cnt + 1;
    end

    task automatic tally_and_finish();
        begin
            $display("compares %0d errors %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] e);
        begin
            cmp_count++;
            if (got !== e)
            begin
                num_errors++;
                $display("mismatch at %0t got %h expected %h", $time, got, e);
            end
        end
    endtask

    task automatic check_bit(input logic got, input logic e);
        begin
            cmp_count++;
            if (got !== e)
            begin
                num_errors++;
                $display("mismatch at %0t got %h expected %h", $time, got, e);
            end
        end
    endtask

    task automatic tick(input int n);
        begin
            repeat (n) @(posedge ref_clk);
        end
    endtask

    // bounded wait on busy; a hang ends the run as a failure
    task automatic wait_busy(input logic lvl, output int n);
        begin
            for (n = 0; n < 1000 && busy !== lvl; n++)
                @(posedge ref_clk);
            if (busy !== lvl)
            begin
                num_errors++;
                tally_and_finish();
            end
        end
    endtask

    // one conversion; the model keeps only the newest unread word
    task automatic convert(input logic pdm);
        int n;
        int d;
        logic [31:0] w;
        begin
            code_a <= 16'($urandom);
            code_b <= 16'($urandom);
            conversion_start_n <= 1'b0;
            d = done_cnt;
            wait_busy(1'b1, n);
            check_bit(hold, 1'b1);
            conversion_start_n <= 1'b1;
            power_down <= pdm;
            wait_busy(1'b0, n);
            check_word(32'(done_cnt - d), 32'h0000_0002);
            power_down <= 1'b0;
            w = channel_order_select ? {code_b, code_a} : {code_a, code_b};
            exp_q.delete();
            exp_q.push_back(w);
            tick(ACQ_CYC + 4);
            check_word(32'(done_cnt - d), 32'h0000_0002);
        end
    endtask

    // master read; with read mode high it runs beside a new conversion
    task automatic master_scn(input logic rm, input logic fi);
        logic [31:0] w;
        logic [31:0] e;
        logic ok;
        logic bsy;
        int n;
        int g;
        begin
            port_type_select <= 1'b1;
            clock_source_select <= 1'b0;
            read_mode_or_chain_in <= rm;
            frame_marker_invert <= fi;
            serial_clock_invert <= 1'($urandom);
            if (!rm)
                channel_order_select <= 1'($urandom);
            tick(4);
            if (!rm)
                convert(1'b0);
            e = exp_q[0];
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            fork
                if (rm)
                    convert(1'b0);
                begin
                    for (n = 0; n < 50; n++)
                    begin
                        if (d_oe[PIN_FRAME] === 1'b1
                            && d_out[PIN_FRAME] === ~fi)
                            break;
                        @(posedge ref_clk);
                    end
                    if (n == 50)
                    begin
                        num_errors++;
                        tally_and_finish();
                    end
                    g = gap_cnt;
                    in_read <= 1'b1;
                    host.master_read(w, ok);
                    bsy = busy;
                    check_bit(d_oe[PIN_SCLK], 1'b1);
                    check_bit(d_oe[PIN_FRAME], 1'b1);
                    check_word(32'(d_oe[15:PIN_UPPER]), 32'h0000_0000);
                    in_read <= 1'b0;
                    tick(1);
                    g = gap_cnt - g;
                end
            join
            check_bit(ok, 1'b1);
            check_word(w, e);
            check_bit(bsy, rm);
            if (!fi)
                check_word(32'(g), 32'(SCLK_HALF_CYC));
            else
                check_word(32'(g), 32'(SCLK_HALF_CYC));
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            tick(2);
        end
    endtask

    // slave read of the word then eight chained bits, chain held high
    task automatic slave_scn(input logic inv);
        logic [39:0] w;
        begin
            port_type_select <= 1'b1;
            clock_source_select <= 1'b1;
            serial_clock_invert <= inv;
            read_mode_or_chain_in <= 1'b1;
            tick(4);
            convert(1'b0);
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            tick(6);
            check_bit(d_oe[PIN_RDERR], 1'b1);
            check_bit(d_oe[PIN_FRAME], 1'b0);
            check_bit(d_oe[PIN_SCLK], 1'b0);
            host.slave_read(40, w);
            check_word(w[39:8], exp_q[0]);
            check_word(32'(w[7:0]), 32'h0000_00ff);
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            tick(4);
        end
    endtask

    initial
    begin
        logic [39:0] w;
        int n;
        int r;
        void'($urandom(32'h0000_46ce));
        tick(8);
        rst <= 1'b0;
        tick(3);
        check_bit(busy, 1'b0);
        check_bit(channel_done_n, 1'b1);
        check_word(32'(d_oe), 32'h0000_0000);
        // reset in mid-conversion: no done pulse may follow
        conversion_start_n <= 1'b0;
        wait_busy(1'b1, n);
        tick(20);
        rst <= 1'b1;
        conversion_start_n <= 1'b1;
        tick(3);
        rst <= 1'b0;
        r = done_cnt;
        tick(250);
        check_bit(busy, 1'b0);
        check_word(32'(done_cnt - r), 32'h0000_0000);
        // power-down refuses a start, then is raised mid-conversion
        power_down <= 1'b1;
        conversion_start_n <= 1'b0;
        tick(30);
        check_bit(busy, 1'b0);
        conversion_start_n <= 1'b1;
        power_down <= 1'b0;
        tick(4);
        convert(1'b1);
        // low-power mode restarts while start stays low
        low_power_mode <= 1'b1;
        conversion_start_n <= 1'b0;
        wait_busy(1'b1, n);
        wait_busy(1'b0, n);
        wait_busy(1'b1, n);
        check_bit(n <= ACQ_CYC + 8, 1'b1);
        conversion_start_n <= 1'b1;
        low_power_mode <= 1'b0;
        wait_busy(1'b0, n);
        tick(ACQ_CYC + 4);
        master_scn(1'b0, 1'b0);
        master_scn(1'b0, 1'b1);
        convert(1'b0);
        master_scn(1'b1, 1'b0);
        slave_scn(1'b0);
        slave_scn(1'b1);
        // slave read cut short by new results is dropped and flagged
        convert(1'b0);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        tick(6);
        host.slave_read(8, w);
        r = rderr_cnt;
        convert(1'b0);
        check_word(32'(rderr_cnt - r), 32'h0000_0001);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(2);
        // the read restarted on the flagged results died with the select
        convert(1'b0);
        host.slave_read(5, w);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        tick(6);
        host.slave_read(32, w);
        check_word(w[31:0], exp_q[0]);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        // parallel port shows the selected channel while enabled
        port_type_select <= 1'b0;
        for (n = 0; n < 2; n++)
        begin
            channel_order_select <= n[0];
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            tick(5);
            check_word(32'(d_oe), 32'h0000_ffff);
            check_word(32'(d_out), 32'(n[0] ? code_b : code_a));
            rd_n <= 1'b1;
            tick(5);
            check_word(32'(d_oe), 32'h0000_0000);
            cs_n <= 1'b1;
            tick(1);
        end
        tally_and_finish();
    end
endmodule
